// [pkg/ssr_pkg.sv]
package ssr_pkg;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 16;
  localparam logic [6:0]  ADDR_RESET_CMD   = 7'h1d;
  localparam logic [6:0]  ADDR_ALARM_FLAGS = 7'h1e;
  localparam logic [6:0]  ADDR_GEN_FLAGS   = 7'h1f;
  localparam logic [15:0] RESET_VALUE      = 16'h0000;
  localparam logic [3:0]  RESET_CODE       = 4'hc;
  localparam int unsigned RESET_CODE_LSB   = 0;
  localparam int unsigned NUM_CHAN         = 4;
  localparam int unsigned NUM_SRC          = 6;
  localparam int unsigned ALM_OUT_LSB      = 12;
  localparam int unsigned ALM_NEG_SUPPLY   = 10;
  localparam int unsigned ALM_R2_UNDER     = 8;
  localparam int unsigned ALM_R1_UNDER     = 6;
  localparam int unsigned ALM_LT_UNDER     = 4;
  localparam int unsigned GEN_ANY_NEW      = 15;
  localparam int unsigned GEN_READY        = 14;
  localparam int unsigned GEN_SRC_LSB      = 8;
  localparam int unsigned GEN_DOZE_LSB     = 2;
  localparam int unsigned GEN_AMP_EN       = 1;
  localparam int unsigned GEN_ANY_FAULT    = 0;
  localparam int unsigned SETTLE_CYCLES    = 4;
  localparam int unsigned RESET_PULSE_CYC  = 2;
  typedef enum logic [1:0] {
    SSR_RDY_IDLE   = 2'b00,
    SSR_RDY_READY  = 2'b01,
    SSR_RDY_BUSY   = 2'b11,
    SSR_RDY_SETTLE = 2'b10
  } ssr_ready_e;
endpackage

// [src/ssr_ready_fsm.sv]
module ssr_ready_fsm
  import ssr_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_clear,
  input  wire logic i_powered,
  input  wire logic i_trigger,
  input  wire logic i_running,
  input  wire logic i_stop_write,
  output logic      o_ready
);
  ssr_ready_e state_q;
  logic [2:0] settle_q;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q  <= SSR_RDY_IDLE;
      settle_q <= 3'h0;
    end else if (i_clear) begin
      state_q  <= SSR_RDY_IDLE;
      settle_q <= 3'h0;
    end else begin
      case (state_q)
        SSR_RDY_IDLE: begin
          if (i_powered) begin
            state_q <= SSR_RDY_READY;
          end
        end
        SSR_RDY_READY: begin
          if (i_stop_write) begin
            state_q  <= SSR_RDY_SETTLE;
            settle_q <= 3'(SETTLE_CYCLES);
          end else if (i_trigger) begin
            state_q <= SSR_RDY_BUSY;
          end
        end
        SSR_RDY_BUSY: begin
          if (i_stop_write) begin
            state_q  <= SSR_RDY_SETTLE;
            settle_q <= 3'(SETTLE_CYCLES);
          end else if (!i_running) begin
            state_q <= SSR_RDY_READY;
          end
        end
        default: begin
          if (i_stop_write) begin
            settle_q <= 3'(SETTLE_CYCLES);
          end else if (settle_q == 3'h0) begin
            state_q <= SSR_RDY_IDLE;
          end else begin
            settle_q <= settle_q - 3'h1;
          end
        end
      endcase
    end
  end

  assign o_ready = (state_q == SSR_RDY_READY);

  chk_trigger_drops: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (o_ready && i_trigger && !i_stop_write && !i_clear) |=> !o_ready)
    else $error("ready stayed high after trigger");
  chk_settle_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_stop_write |=> !o_ready [*5])
    else $error("ready returned before settling");
endmodule

// [src/ssr_reset_cmd.sv]
module ssr_reset_cmd
  import ssr_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_wr_en,
  input  wire logic [15:0] i_wr_data,
  output logic             o_soft_reset
);
  logic [1:0] cnt_q;
  logic       pend_q;

  // Only the exact code fires; other codes leave state alone
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_q <= 1'b0;
      cnt_q  <= 2'h0;
    end else if (i_wr_en && i_wr_data[RESET_CODE_LSB +: 4] == RESET_CODE) begin
      pend_q <= 1'b1;
      cnt_q  <= 2'(RESET_PULSE_CYC - 1);
    end else if (pend_q) begin
      if (cnt_q == 2'h0) begin
        pend_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end

  assign o_soft_reset = pend_q;

  chk_code_fires: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_wr_en && i_wr_data[3:0] == 4'hc) |=> o_soft_reset [*2] ##1 !o_soft_reset)
    else $error("reset code did not pulse two cycles");
  chk_other_codes: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (!o_soft_reset && !(i_wr_en && i_wr_data[3:0] == 4'hc)) |=> !o_soft_reset)
    else $error("soft reset without code");
endmodule

// [src/ssr_status_regs.sv]
module ssr_status_regs
  import ssr_pkg::*;
#(
  parameter int unsigned NCHAN = NUM_CHAN,
  parameter int unsigned NSRC  = NUM_SRC
) (
  input  wire logic                         i_clock,
  input  wire logic                         i_rst_n,
  input  wire logic                         i_wr_en,
  input  wire logic                         i_rd_en,
  input  wire logic [ssr_pkg::ADDR_W-1:0]   i_addr,
  input  wire logic [ssr_pkg::DATA_W-1:0]   i_wr_data,
  output logic      [ssr_pkg::DATA_W-1:0]   o_rd_data,
  output logic                              o_soft_reset,
  input  wire logic [NCHAN-1:0]             i_out_value_high,
  input  wire logic                         i_neg_supply_bad,
  input  wire logic                         i_remote1_enable,
  input  wire logic                         i_remote2_enable,
  input  wire logic                         i_onchip_enable,
  input  wire logic                         i_remote1_over,
  input  wire logic                         i_remote1_under,
  input  wire logic                         i_remote2_over,
  input  wire logic                         i_remote2_under,
  input  wire logic                         i_onchip_over,
  input  wire logic                         i_onchip_under,
  input  wire logic [NCHAN-1:0]             i_chan_out_of_range,
  input  wire logic                         i_conv_powered,
  input  wire logic                         i_conv_trigger,
  input  wire logic                         i_conv_running,
  input  wire logic                         i_conv_stop_write,
  input  wire logic [NSRC-1:0]              i_src_result_done,
  input  wire logic [NSRC-1:0]              i_src_result_read,
  input  wire logic                         i_doze_pin1_level,
  input  wire logic                         i_doze_pin2_level,
  input  wire logic                         i_amp_enable_pin_level
);
  import ssr_pkg::*;

  logic [DATA_W-1:0] alarm_flags_q;
  logic [DATA_W-1:0] alarm_flags_d;
  logic [NSRC-1:0]   src_new_q;
  logic [3:0]        pins_q;
  logic [DATA_W-1:0] general_flags;
  logic              conv_ready;
  logic              wr_reset_cmd;
  logic              rd_data_sel_alarm;

  assign wr_reset_cmd = i_wr_en && (i_addr == ADDR_RESET_CMD);

  ssr_reset_cmd u_reset_cmd (
    .i_clock      (i_clock),
    .i_rst_n      (i_rst_n),
    .i_wr_en      (wr_reset_cmd),
    .i_wr_data    (i_wr_data),
    .o_soft_reset (o_soft_reset)
  );

  ssr_ready_fsm u_ready (
    .i_clock      (i_clock),
    .i_rst_n      (i_rst_n),
    .i_clear      (o_soft_reset),
    .i_powered    (i_conv_powered),
    .i_trigger    (i_conv_trigger),
    .i_running    (i_conv_running),
    .i_stop_write (i_conv_stop_write),
    .o_ready      (conv_ready)
  );

  // Alarm flags follow live conditions, registered once for clean reads
  always_comb begin
    alarm_flags_d = RESET_VALUE;
    alarm_flags_d[ALM_OUT_LSB +: NCHAN] = i_out_value_high;
    alarm_flags_d[ALM_NEG_SUPPLY] = i_neg_supply_bad;
    alarm_flags_d[ALM_R2_UNDER + 1] = i_remote2_enable && i_remote2_over;
    alarm_flags_d[ALM_R2_UNDER]     = i_remote2_enable && i_remote2_under;
    alarm_flags_d[ALM_R1_UNDER + 1] = i_remote1_enable && i_remote1_over;
    alarm_flags_d[ALM_R1_UNDER]     = i_remote1_enable && i_remote1_under;
    alarm_flags_d[ALM_LT_UNDER + 1] = i_onchip_enable && i_onchip_over;
    alarm_flags_d[ALM_LT_UNDER]     = i_onchip_enable && i_onchip_under;
    alarm_flags_d[0 +: NCHAN] = i_chan_out_of_range;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alarm_flags_q <= RESET_VALUE;
    end else if (o_soft_reset) begin
      alarm_flags_q <= RESET_VALUE;
    end else begin
      alarm_flags_q <= alarm_flags_d;
    end
  end

  // New-result flags: set wins over a same-cycle read clear
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_src
      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          src_new_q[g] <= 1'b0;
        end else if (o_soft_reset) begin
          src_new_q[g] <= 1'b0;
        end else if (i_src_result_done[g]) begin
          src_new_q[g] <= 1'b1;
        end else if (i_src_result_read[g]) begin
          src_new_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pins_q <= 4'h0;
    end else begin
      pins_q <= {i_doze_pin2_level, i_doze_pin1_level, i_amp_enable_pin_level,
                 |alarm_flags_q};
    end
  end

  always_comb begin
    general_flags = RESET_VALUE;
    general_flags[GEN_ANY_NEW]  = |src_new_q;
    general_flags[GEN_READY]    = conv_ready;
    general_flags[GEN_SRC_LSB +: NSRC] = src_new_q;
    general_flags[GEN_DOZE_LSB +: 2]   = pins_q[3:2];
    general_flags[GEN_AMP_EN]    = pins_q[1];
    general_flags[GEN_ANY_FAULT] = pins_q[0];
  end

  assign rd_data_sel_alarm = i_addr == ADDR_ALARM_FLAGS;

  // Writes to the status addresses are dropped; reset register reads zero
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= RESET_VALUE;
    end else if (i_rd_en) begin
      if (rd_data_sel_alarm) begin
        o_rd_data <= alarm_flags_q;
      end else if (i_addr == ADDR_GEN_FLAGS) begin
        o_rd_data <= general_flags;
      end else begin
        o_rd_data <= RESET_VALUE;
      end
    end
  end

  chk_remote_gate: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (!i_remote2_enable && !i_remote1_enable) |=> (alarm_flags_q[9:6] == 4'h0))
    else $error("remote alarm set while sensor disabled");
  chk_onchip_gate: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !i_onchip_enable |=> (alarm_flags_q[5:4] == 2'h0))
    else $error("onchip alarm set while sensor disabled");
  chk_out_limit: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_out_value_high[3] && !o_soft_reset) |=> alarm_flags_q[15])
    else $error("output four over limit not flagged");
  chk_out12_limit: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_out_value_high[0] && !o_soft_reset) |=> alarm_flags_q[12])
    else $error("output one over limit not flagged");
  chk_neg_supply: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_neg_supply_bad && !o_soft_reset) |=> (alarm_flags_q[10] && !alarm_flags_q[11]))
    else $error("negative supply fault wrong");
  chk_remote1_over: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_remote1_enable && i_remote1_over && !o_soft_reset) |=> alarm_flags_q[7])
    else $error("remote one over not flagged");
  chk_remote2_under: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_remote2_enable && i_remote2_under && !o_soft_reset) |=> alarm_flags_q[8])
    else $error("remote two under not flagged");
  chk_onchip_over: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_onchip_enable && i_onchip_over && !o_soft_reset) |=> alarm_flags_q[5])
    else $error("onchip over not flagged");
  chk_chan_fault: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !o_soft_reset |=> (alarm_flags_q[3:0] == $past(i_chan_out_of_range)))
    else $error("channel fault bits mismatch");
  chk_new_set: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_src_result_done[0] && !o_soft_reset) |=> (src_new_q[0] ##1 1'b1))
    else $error("new result flag not set");
  chk_gen_layout: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_rd_en && i_addr == ADDR_GEN_FLAGS) |=> (o_rd_data[7:4] == 4'h0
      && o_rd_data[15] == |o_rd_data[13:8]))
    else $error("general flags layout wrong");
  chk_soft_clears: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_soft_reset |=> (alarm_flags_q == 16'h0000 && src_new_q == '0))
    else $error("soft reset left state");
endmodule

// [testbench/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ssr_pkg::*;

  logic        i_clock = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_wr_en = 1'b0;
  logic        i_rd_en = 1'b0;
  logic [6:0]  i_addr = 7'h00;
  logic [15:0] i_wr_data = 16'h0000;
  logic [15:0] o_rd_data;
  logic        o_soft_reset;
  logic [3:0]  i_out_value_high = 4'h0;
  logic [3:0]  i_chan_out_of_range = 4'h0;
  logic        i_neg_supply_bad = 1'b0;
  logic        i_remote1_enable = 1'b0, i_remote2_enable = 1'b0, i_onchip_enable = 1'b0;
  logic        i_remote1_over = 1'b0, i_remote1_under = 1'b0;
  logic        i_remote2_over = 1'b0, i_remote2_under = 1'b0;
  logic        i_onchip_over = 1'b0, i_onchip_under = 1'b0;
  logic        i_conv_powered = 1'b0, i_conv_trigger = 1'b0;
  logic        i_conv_running = 1'b0, i_conv_stop_write = 1'b0;
  logic [5:0]  i_src_result_done = 6'h00;
  logic [5:0]  i_src_result_read = 6'h00;
  logic        i_doze_pin1_level = 1'b0, i_doze_pin2_level = 1'b0;
  logic        i_amp_enable_pin_level = 1'b0;
  int          error_cnt = 0;
  int          check_count = 0;

  ssr_status_regs i_ssr_status_regs (
    .i_clock, .i_rst_n, .i_wr_en, .i_rd_en, .i_addr, .i_wr_data, .o_rd_data,
    .o_soft_reset, .i_out_value_high, .i_neg_supply_bad, .i_remote1_enable,
    .i_remote2_enable, .i_onchip_enable, .i_remote1_over, .i_remote1_under,
    .i_remote2_over, .i_remote2_under, .i_onchip_over, .i_onchip_under,
    .i_chan_out_of_range, .i_conv_powered, .i_conv_trigger, .i_conv_running,
    .i_conv_stop_write, .i_src_result_done, .i_src_result_read,
    .i_doze_pin1_level, .i_doze_pin2_level, .i_amp_enable_pin_level
  );

  always #10 i_clock = ~i_clock;

  task automatic tally_and_finish();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge i_clock);
  endtask

  task automatic wr(logic [6:0] a, logic [15:0] d);
    @(posedge i_clock);
    i_wr_en <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_clock);
    i_wr_en <= 1'b0;
  endtask

  // Read data lands on the edge that samples the strobe
  task automatic rchk(string n, logic [6:0] a, logic [15:0] m, logic [15:0] e);
    @(posedge i_clock);
    i_rd_en <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd_en <= 1'b0;
    #1 chk(n, o_rd_data & m, e);
  endtask

  // Counts pulse cycles, tolerant of where the pulse starts
  task automatic wcnt(logic [15:0] d, int e);
    int cnt;
    cnt = 0;
    wr(ADDR_RESET_CMD, d);
    #1 cnt += int'(o_soft_reset === 1'b1);
    repeat (4) begin
      @(posedge i_clock);
      #1 cnt += int'(o_soft_reset === 1'b1);
    end
    chk("soft_reset_cycles", 16'(cnt), 16'(e));
  endtask

  task automatic alm(logic [15:0] v, logic [2:0] en);
    @(posedge i_clock);
    i_out_value_high <= v[15:12];
    i_neg_supply_bad <= v[10];
    {i_remote2_over, i_remote2_under, i_remote1_over, i_remote1_under} <= v[9:6];
    {i_onchip_over, i_onchip_under} <= v[5:4];
    i_chan_out_of_range <= v[3:0];
    {i_onchip_enable, i_remote2_enable, i_remote1_enable} <= en;
    cyc(3);
  endtask

  task automatic src(logic [5:0] dn, logic [5:0] rdv);
    @(posedge i_clock);
    i_src_result_done <= dn;
    i_src_result_read <= rdv;
    @(posedge i_clock);
    i_src_result_done <= 6'h00;
    i_src_result_read <= 6'h00;
    cyc(3);
  endtask

  logic [15:0] em [4] = '{16'h00c0, 16'h0300, 16'h0030, 16'h0000};
  logic [2:0]  ens [4] = '{3'b001, 3'b010, 3'b100, 3'b000};

  initial begin
    cyc(8);
    i_rst_n <= 1'b1;
    cyc(2);
    rchk("alarm_reset", ADDR_ALARM_FLAGS, 16'hffff, 16'h0000);
    rchk("gen_reset", ADDR_GEN_FLAGS, 16'hffff, 16'h0000);
    wr(ADDR_ALARM_FLAGS, 16'hffff);
    wr(ADDR_GEN_FLAGS, 16'hffff);
    rchk("alarm_ro", ADDR_ALARM_FLAGS, 16'hffff, 16'h0000);
    rchk("gen_ro", ADDR_GEN_FLAGS, 16'hffff, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      alm(16'h0001 << i, 3'b111);
      rchk("alarm_bit", ADDR_ALARM_FLAGS, 16'hffff, (16'h0001 << i) & 16'hf7ff);
      rchk("any_fault", ADDR_GEN_FLAGS, 16'h0001, {15'h0000, i != 11});
    end
    // Temperature alarms all raised, one sensor enabled at a time, then none enabled
    for (int k = 0; k < 4; k++) begin
      alm(16'h03f0, ens[k]);
      rchk("temp_enable", ADDR_ALARM_FLAGS, 16'hffff, em[k]);
    end
    alm(16'h0000, 3'b111);
    @(posedge i_clock);
    i_conv_powered <= 1'b1;
    i_doze_pin2_level <= 1'b1;
    i_amp_enable_pin_level <= 1'b1;
    cyc(3);
    rchk("gen_pins", ADDR_GEN_FLAGS, 16'hffff, 16'h400a);
    i_doze_pin2_level <= 1'b0;
    i_amp_enable_pin_level <= 1'b0;
    i_doze_pin1_level <= 1'b1;
    cyc(3);
    rchk("gen_pins", ADDR_GEN_FLAGS, 16'hffff, 16'h4004);
    i_conv_trigger <= 1'b1;
    i_conv_running <= 1'b1;
    @(posedge i_clock);
    i_conv_trigger <= 1'b0;
    cyc(2);
    rchk("ready_run", ADDR_GEN_FLAGS, 16'h4000, 16'h0000);
    i_conv_running <= 1'b0;
    cyc(3);
    rchk("ready_stop", ADDR_GEN_FLAGS, 16'h4000, 16'h4000);
    i_conv_stop_write <= 1'b1;
    @(posedge i_clock);
    i_conv_stop_write <= 1'b0;
    rchk("ready_settle", ADDR_GEN_FLAGS, 16'h4000, 16'h0000);
    cyc(12);
    rchk("ready_back", ADDR_GEN_FLAGS, 16'h4000, 16'h4000);
    for (int i = 0; i < 6; i++) begin
      src(6'h01 << i, 6'h00);
      rchk("new_set", ADDR_GEN_FLAGS, 16'hbf00, 16'h8000 | (16'h0100 << i));
      src(6'h00, 6'h01 << i);
      rchk("new_clear", ADDR_GEN_FLAGS, 16'hbf00, 16'h0000);
    end
    // Pending flag must survive every wrong code
    src(6'h20, 6'h00);
    for (int c = 0; c < 16; c++) begin
      if (c != 12) wcnt(16'(c), 0);
    end
    rchk("wrong_code", ADDR_GEN_FLAGS, 16'hbf00, 16'ha000);
    wcnt({12'h000, RESET_CODE}, 2);
    rchk("soft_reset", ADDR_GEN_FLAGS, 16'hbf00, 16'h0000);
    rchk("reset_cmd_reads_zero", ADDR_RESET_CMD, 16'hffff, 16'h0000);
    wcnt(16'h0000, 0);
    wcnt({12'h000, RESET_CODE}, 2);
    tally_and_finish();
  end

  initial begin
    #100000;
    error_cnt++;
    $display("Error watchdog expected done seen timeout");
    tally_and_finish();
  end
endmodule
